// ==== eee_debug_chip_caps_regs.v ====
`timescale 1ns/1ns
`include "eee_defines.vh"
module eee_debug_chip_caps_regs #(
   parameter        IND_TEMP     = 1'b0,
   parameter        QUAD_PORT    = 1'b1,
   parameter        PTP_CAP      = 1'b1,
   parameter        SEC_CAP      = 1'b1,
   parameter        DUAL_MEDIA   = 1'b1,
   parameter        HI_PREC      = 1'b1,
   parameter        KEY256       = 1'b1,
   parameter [7:0]  VARIANT_BCD  = 8'h42  // arbitrary value
) (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // port state
   input  wire        soft_reset,
   input  wire        link_up,
   input  wire        eee_en_1000,
   input  wire        eee_en_100,
   input  wire [1:0]  speed_sel,
   input  wire        mode_1000,
   input  wire        mode_100,
   input  wire        fiber_unidir,
   // lpi paths
   input  wire        mac_tx_lpi,
   input  wire        mdi_rx_lpi,
   output reg         mdi_tx_lpi,
   output reg         mac_rx_lpi,
   output reg         mac_tx_ignore,
   // indicators
   input  wire [15:0] indicator_active,
   input  wire        serial_mode,
   input  wire [3:0]  serial_active,
   output reg  [15:0] indicator_outputs,
   output reg  [3:0]  serial_indicator,
   // mode controls
   output reg         te_enable,
   output reg         force_1000_nomaster
);
   reg  [15:0] page_sel;
   reg  [15:0] ctrl;
   reg  [15:0] lfsr;
   reg         ph_valid;
   reg         ph_write;
   reg  [4:0]  ph_idx;
   wire [15:0] status_bits;
   wire [15:0] ident;
   wire        on_page2;
   wire        take;
   wire [3:0]  inv;
   reg  [15:0] rd_word;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign take      = hsel & hready & htrans[1];
   assign on_page2  = (page_sel == `EEE_PAGE_EXT2);
   assign inv       = ctrl[`EEE_B_INV_HI:`EEE_B_INV_LO];
   // live status in bits 8:6, bit 9 reserved zero
   assign status_bits = {7'h00, link_up, eee_en_1000, eee_en_100, 6'h00};
   assign ident = {IND_TEMP[0], QUAD_PORT[0], PTP_CAP[0], SEC_CAP[0],
                   1'b0, DUAL_MEDIA[0], HI_PREC[0], KEY256[0],
                   VARIANT_BCD};
   // address phase capture
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_idx   <= 5'h00;
      end else if (hready) begin
         ph_valid <= take;
         ph_write <= hwrite;
         ph_idx   <= haddr[6:2];
      end
   end
   // soft reset leaves sticky control alone
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl     <= `EEE_CTRL_RESET;
         page_sel <= `EEE_PAGE_MAIN;
      end else if (soft_reset) begin
         page_sel <= `EEE_PAGE_MAIN;
      end else if (ph_valid & ph_write) begin
         if (ph_idx == `EEE_IDX_PAGE)
            page_sel <= hwdata[15:0];
         else if (on_page2 && ph_idx == `EEE_IDX_CTRL)
            ctrl <= hwdata[15:0] & `EEE_CTRL_WMASK;
      end
   end
   // free-running lfsr; advances every clock whether read or not, so consecutive reads differ
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         lfsr <= `EEE_LFSR_SEED;
      else
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[14] ^ lfsr[12] ^ lfsr[3]};
   end
   always @* begin
      rd_word = 16'h0000;
      if (ph_idx == `EEE_IDX_PAGE)
         rd_word = page_sel;
      else if (on_page2) begin
         case (ph_idx)
            `EEE_IDX_CTRL:    rd_word = ctrl | status_bits;
            `EEE_IDX_IDENT:   rd_word = ident;
            `EEE_IDX_ENTROPY: rd_word = lfsr;
            default:          rd_word = 16'h0000;
         endcase
      end
   end
   // read data registered at the end of the address phase for timing
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take & ~hwrite) begin
         if (haddr[6:2] == `EEE_IDX_PAGE)
            hrdata <= {16'h0000, page_sel};
         else if (on_page2 && haddr[6:2] == `EEE_IDX_CTRL)
            hrdata <= {16'h0000, ctrl | status_bits};
         else if (on_page2 && haddr[6:2] == `EEE_IDX_IDENT)
            hrdata <= {16'h0000, ident};
         else if (on_page2 && haddr[6:2] == `EEE_IDX_ENTROPY)
            hrdata <= {16'h0000, lfsr};
         else
            hrdata <= 32'h0000_0000;
      end
   end
   // datapath effects
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mdi_tx_lpi          <= 1'b0;
         mac_rx_lpi          <= 1'b0;
         mac_tx_ignore       <= 1'b0;
         indicator_outputs   <= 16'hffff;
         serial_indicator    <= 4'hf;
         te_enable           <= 1'b0;
         force_1000_nomaster <= 1'b0;
      end else begin
         te_enable     <= ctrl[`EEE_B_TE];
         force_1000_nomaster <= ctrl[`EEE_B_FORCE_1000] &
                                (speed_sel == `EEE_SPEED_1000);
         mac_tx_ignore <= ctrl[`EEE_B_FORCE_LPI];
         if (ctrl[`EEE_B_FORCE_LPI])
            mdi_tx_lpi <= 1'b1;
         else
            mdi_tx_lpi <= mac_tx_lpi
               & ~(mode_100 & ctrl[`EEE_B_INH_TX100])
               & ~(mode_1000 & ctrl[`EEE_B_INH_TX1000]);
         mac_rx_lpi <= mdi_rx_lpi
            & ~(mode_100 & ctrl[`EEE_B_INH_RX100])
            & ~(mode_1000 & ctrl[`EEE_B_INH_RX1000]);
         // default active low; inversion bit per group of four
         indicator_outputs <= ~(indicator_active
            & {16{~fiber_unidir | ctrl[`EEE_B_LED_UNI]}})
            ^ {{4{inv[3]}}, {4{inv[2]}}, {4{inv[1]}}, {4{inv[0]}}};
         serial_indicator <= serial_mode ? (~serial_active ^ inv) : 4'hf;
      end
   end
endmodule // eee_debug_chip_caps_regs

// ==== eee_debug_chip_caps_regs_properties.sv ====
`timescale 1ns/1ns
module eee_regs_props (
   // clock and reset
   input wire        hclk,
   input wire        hresetn,
   // bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   // port side
   input wire [1:0]  speed_sel,
   input wire        mac_tx_lpi,
   input wire        mdi_rx_lpi,
   input wire        mdi_tx_lpi,
   input wire        mac_rx_lpi,
   input wire        mac_tx_ignore,
   input wire        force_1000_nomaster
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_req;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_unmapped_zero: assert property (rd_req ##0
      !(haddr inside {32'h44, 32'h48, 32'h4c, 32'h7c}) |=> hrdata == 0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (rd_req |=> hrdata[31:16] == 0)
      else $error("upper half set");
   a_ident_rsvd: assert property (rd_req ##0 haddr == 32'h48 |=> !hrdata[11])
      else $error("reserved ident bit set");
   a_rx_source: assert property (mac_rx_lpi |-> $past(mdi_rx_lpi))
      else $error("rx idle without cause");
   a_tx_source: assert property (mdi_tx_lpi |-> $past(mac_tx_lpi) || mac_tx_ignore)
      else $error("tx idle without cause");
   a_ignore_lpi: assert property (mac_tx_ignore |-> mdi_tx_lpi)
      else $error("forced idle not sent");
   a_force_speed: assert property (force_1000_nomaster |-> $past(speed_sel) == 2'b10)
      else $error("force mode at wrong speed");
endmodule // eee_regs_props
bind eee_debug_chip_caps_regs eee_regs_props i_props (.*);

// ==== eee_debug_chip_caps_regs_tb.sv ====
`timescale 1ns/1ns
module eee_debug_chip_caps_regs_tb;
   logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, soft_reset = 0, link_up = 1;
   logic        eee_en_1000 = 1, mode_1000 = 1, mode_100 = 0, mac_tx_lpi = 1;
   logic        mdi_rx_lpi = 1, serial_mode = 1, fiber_unidir = 0, eee_en_100 = 0;
   logic [1:0]  htrans = 0, speed_sel = 2'b10;
   logic [3:0]  serial_active = 4'h3;
   logic [15:0] indicator_active = 16'h0001;
   logic [31:0] haddr = 0, hwdata = 0, r, q;
   logic [19:0] tbl [8];
   wire         hreadyout, hresp, mdi_tx_lpi, mac_rx_lpi, mac_tx_ignore, te_enable;
   wire         force_1000_nomaster;
   wire  [3:0]  serial_indicator;
   wire  [15:0] indicator_outputs;
   wire  [31:0] hrdata;
   int          errors = 0, n_compared = 0;
   eee_debug_chip_caps_regs i_eee_debug_chip_caps_regs (.*, .hready(hreadyout),
      .hsize(3'h2));
   always #2 hclk = ~hclk;
   task automatic xfer(input [31:0] a, input w, input [31:0] d);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input [31:0] got, input [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(input [31:0] a, input [31:0] exp);
      xfer(a, 0, 0);
      chk(r, exp);
   endtask
   task wrap_up;
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      wrap_up;
   end
   initial begin
      // {speed 1000, control, tx idle, rx idle, mac ignored}
      tbl = '{20'h80006, 20'h8000c, 20'h80012, 20'h80066, 20'h80087, 20'h00042,
         20'h00024, 20'h0001e};
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      rd(32'h44, 32'h0);
      xfer(32'h7c, 1, 32'h2);
      rd(32'h44, 32'h0180);
      xfer(32'h44, 1, 32'hffff_ffff);
      rd(32'h44, 32'hfdbf);
      chk({te_enable, force_1000_nomaster, serial_indicator, indicator_outputs}, 22'h330001);
      foreach (tbl[i]) begin
         mode_1000 <= tbl[i][19];
         mode_100 <= !tbl[i][19];
         mac_tx_lpi <= !tbl[i][0];
         xfer(32'h44, 1, {16'h0, tbl[i][18:3]});
         repeat (3) @(posedge hclk);
         chk({mdi_tx_lpi, mac_rx_lpi, mac_tx_ignore}, tbl[i][2:0]);
      end
      chk({force_1000_nomaster, serial_indicator, indicator_outputs}, 21'h0cfffe);
      fiber_unidir <= 1;
      eee_en_100 <= 1;
      repeat (2) @(posedge hclk);
      chk(indicator_outputs, 32'hffff);
      rd(32'h44, 32'h01c3);
      xfer(32'h44, 1, 32'h4000);
      repeat (3) @(posedge hclk);
      chk(indicator_outputs, 32'hfffe);
      soft_reset <= 1;
      @(posedge hclk);
      soft_reset <= 0;
      rd(32'h44, 32'h0);
      xfer(32'h7c, 1, 32'h2);
      rd(32'h44, 32'h41c0);
      xfer(32'h48, 1, 32'hffff);
      rd(32'h48, 32'h7742);
      xfer(32'h4c, 0, 0);
      q = r;
      xfer(32'h4c, 0, 0);
      chk({r[31:16], q[31:16]}, 32'h0);
      chk(32'(r != q), 32'h1);
      rd(32'h50, 32'h0);
      hresetn <= 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      xfer(32'h7c, 1, 32'h2);
      rd(32'h44, 32'h01c0);
      wrap_up;
   end
endmodule // eee_debug_chip_caps_regs_tb

// ==== eee_defines.vh ====
`ifndef EEE_DEFINES_VH
`define EEE_DEFINES_VH
// register indices (printed offsets, not multiples of four)
`define EEE_IDX_CTRL      5'h11
`define EEE_IDX_IDENT     5'h12
`define EEE_IDX_ENTROPY   5'h13
// page select register index and page values
`define EEE_IDX_PAGE      5'h1f
`define EEE_PAGE_MAIN     16'h0000
`define EEE_PAGE_EXT2     16'h0002
// control field positions
`define EEE_B_TE          15
`define EEE_B_LED_UNI     14
`define EEE_B_INV_HI      13
`define EEE_B_INV_LO      10
`define EEE_B_RSVD        9
`define EEE_B_LINK        8
`define EEE_B_EEE_1000    7
`define EEE_B_EEE_100     6
`define EEE_B_FORCE_1000  5
`define EEE_B_FORCE_LPI   4
`define EEE_B_INH_TX100   3
`define EEE_B_INH_RX100   2
`define EEE_B_INH_TX1000  1
`define EEE_B_INH_RX1000  0
// writable mask and reset value of the control register
`define EEE_CTRL_WMASK    16'hfc3f
`define EEE_CTRL_RESET    16'h0000
// speed code in control register 0 bits 6,13 for 1000BASE-T
`define EEE_SPEED_1000    2'b10
// entropy lfsr seed, nonzero
`define EEE_LFSR_SEED     16'hace1
`endif
